/* File: afsp_map.svh */
`ifndef AFSP_MAP_SVH
`define AFSP_MAP_SVH
// frame constants
`define AFSP_PREAMBLE      8'h3D
`define AFSP_ID_BASIC      24'h01_0001
`define AFSP_ID_EXTENDED   24'h01_0002
`define AFSP_LEN_BASIC     16'h000D
`define AFSP_CRC_BYTES     2'h2
// payload byte offsets
`define AFSP_OFS_CTRL      16'h0000
`define AFSP_OFS_X         16'h0001
`define AFSP_OFS_Y         16'h0005
`define AFSP_OFS_Z         16'h0009
// control byte field positions
`define AFSP_CTL_XV        0
`define AFSP_CTL_YV        1
`define AFSP_CTL_ZV        2
`define AFSP_CTL_USE       3
// status word bit positions
`define AFSP_SW_RSV_LSB    0
`define AFSP_SW_IMU_LSB    8
`define AFSP_SW_MAG_LSB    40
`define AFSP_SW_BARO_LSB   48
`define AFSP_SW_SAT_LSB    56
// register bus offsets
`define AFSP_REG_CTRL      4'h0
`define AFSP_REG_MODE      4'h1
`define AFSP_REG_STAT_LO   4'h2
`define AFSP_REG_STAT_HI   4'h3
`define AFSP_REG_FIELD_X_GAUSS      4'h4
`define AFSP_REG_FIELD_Y_GAUSS      4'h5
`define AFSP_REG_FIELD_Z_GAUSS      4'h6
`define AFSP_REG_RXINFO    4'h7
`define AFSP_REG_DROPS     4'h8
// reset values
`define AFSP_RST_WORD      32'h0000_0000
`endif

/* File: afsp_pkg.sv */
package afsp_pkg;
  typedef enum logic [2:0] {
    AFSP_HUNT = 3'b000,
    AFSP_ID   = 3'b001,
    AFSP_LEN  = 3'b010,
    AFSP_PAY  = 3'b011,
    AFSP_CRC  = 3'b100
  } afsp_state_t;

  typedef enum logic [7:0] {
    AFSP_VERTICAL_REFERENCE_MODE = 8'h00,
    AFSP_ATTITUDE_HEADING_MODE   = 8'h01,
    AFSP_SATELLITE_INERTIAL_MODE = 8'h02,
    AFSP_PURE_INERTIAL_MODE      = 8'h03
  } afsp_mode_t;

  // inertial field, msb first in listed order; spare bits pad it to 32
  typedef struct packed {
    logic [6:0] spare;
    logic       rsv;
    logic [8:0] sync_count;
    logic [8:0] crc_fail_count;
    logic       sync_fail;
    logic       crc_fail;
    logic       gyro_fail;
    logic       accel_fail;
    logic       align_fail;
    logic       ready;
  } afsp_imu_t;

  typedef struct packed {
    logic [5:0] rsv;
    logic       valid_read;
    logic       ready;
  } afsp_sensor_t;

  typedef struct packed {
    logic [5:0] rsv;
    logic       second_ready;
    logic       first_ready;
  } afsp_sat_t;

  typedef struct packed {
    afsp_sat_t    sat;
    afsp_sensor_t baro;
    afsp_sensor_t mag;
    afsp_imu_t    imu;
    logic [7:0]   rsv;
  } afsp_status_t;

  typedef struct packed {
    logic [31:0] field_x_gauss;
    logic [31:0] field_y_gauss;
    logic [31:0] field_z_gauss;
    logic        x_axis_valid;
    logic        y_axis_valid;
    logic        z_axis_valid;
    logic        apply_measurement;
  } afsp_meas_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } afsp_byte_t;
endpackage

/* File: afsp_packer.sv */
`timescale 1ns/1ps
`include "afsp_map.svh"
module afsp_packer
  import afsp_pkg::*;
#(
  parameter int MAX_PAYLOAD = 16'h005E
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  // serial byte stream from the aiding device
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  // checksum verdict for the frame just ended
  input  wire logic        CRC_OK,
  // sensor status inputs
  input  wire afsp_imu_t   IMU_STATUS,
  input  wire afsp_sensor_t MAG_STATUS,
  input  wire afsp_sensor_t BARO_STATUS,
  input  wire afsp_sat_t   SAT_STATUS,
  // register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // decoded measurement
  output afsp_meas_t       MEAS,
  output logic             MEAS_STROBE,
  output logic             EXT_SEEN,
  // packed words
  output afsp_status_t     STATUS_WORD,
  output logic      [31:0] MODE_WORD
);

  typedef struct packed {
    afsp_state_t  st;
    logic [1:0]   cnt;
    logic [23:0]  id;
    logic [15:0]  len;
    logic [15:0]  idx;
    logic [7:0]   ctl;
    logic [95:0]  xyz;
    afsp_meas_t   meas;
    logic         strobe;
    logic         ext_seen;
    logic         enable;
    afsp_mode_t   mode;
    afsp_status_t stat;
    logic [31:0]  rdata;
    logic [15:0]  drops;
  } afsp_regs_t;

  afsp_regs_t r_q;
  afsp_regs_t r_d;

  // recognised identifier with a length we accept
  function automatic logic frame_known(input logic [23:0] id, input logic [15:0] len);
    frame_known = (id == `AFSP_ID_BASIC && len == `AFSP_LEN_BASIC)
               || (id == `AFSP_ID_EXTENDED && len <= 16'(MAX_PAYLOAD));
  endfunction

  logic good_end;
  assign good_end = r_q.st == AFSP_CRC && RX_VALID && r_q.cnt == 2'h1;

  // next-state logic
  always_comb begin
    r_d = r_q;
    r_d.strobe = 1'b0;
    r_d.stat.rsv = 8'h00;
    r_d.stat.imu = IMU_STATUS;
    r_d.stat.imu.rsv = 1'b0;
    // spare bits pad the field to 32
    r_d.stat.imu.spare = 7'h00;
    r_d.stat.mag = '{rsv: 6'h00, valid_read: MAG_STATUS.valid_read, ready: MAG_STATUS.ready};
    r_d.stat.baro = '{rsv: 6'h00, valid_read: BARO_STATUS.valid_read, ready: BARO_STATUS.ready};
    r_d.stat.sat = '{rsv: 6'h00, second_ready: SAT_STATUS.second_ready,
                     first_ready: SAT_STATUS.first_ready};
    if (RX_VALID && r_q.enable) begin
      unique case (r_q.st)
        AFSP_HUNT: begin
          if (RX_DATA == `AFSP_PREAMBLE) begin
            r_d.st = AFSP_ID;
            r_d.cnt = 2'h0;
          end
        end
        AFSP_ID: begin
          r_d.id = {RX_DATA, r_q.id[23:8]};
          r_d.cnt = r_q.cnt + 2'h1;
          if (r_q.cnt == 2'h2) begin
            r_d.st = AFSP_LEN;
            r_d.cnt = 2'h0;
          end
        end
        AFSP_LEN: begin
          r_d.len = {RX_DATA, r_q.len[15:8]};
          r_d.cnt = r_q.cnt + 2'h1;
          if (r_q.cnt == 2'h1) begin
            r_d.idx = 16'h0000;
            r_d.cnt = 2'h0;
            if (!frame_known(r_q.id, {RX_DATA, r_q.len[15:8]})) begin
              r_d.st = AFSP_HUNT;
              r_d.drops = r_q.drops + 16'h0001;
            end else if ({RX_DATA, r_q.len[15:8]} == 16'h0000) begin
              r_d.st = AFSP_CRC;
            end else begin
              r_d.st = AFSP_PAY;
            end
          end
        end
        AFSP_PAY: begin
          if (r_q.idx == `AFSP_OFS_CTRL) begin
            r_d.ctl = RX_DATA;
          end else if (r_q.idx < `AFSP_OFS_Z + 16'h0004) begin
            r_d.xyz = {RX_DATA, r_q.xyz[95:8]};
          end
          r_d.idx = r_q.idx + 16'h0001;
          if (r_q.idx + 16'h0001 == r_q.len) begin
            r_d.st = AFSP_CRC;
          end
        end
        AFSP_CRC: begin
          r_d.cnt = r_q.cnt + 2'h1;
          if (r_q.cnt == 2'h1) begin
            r_d.st = AFSP_HUNT;
            if (!CRC_OK || r_q.ctl[7:4] != 4'h0) begin
              r_d.drops = r_q.drops + 16'h0001;
            end else begin
              r_d.meas.field_x_gauss = r_q.xyz[31:0];
              r_d.meas.field_y_gauss = r_q.xyz[63:32];
              r_d.meas.field_z_gauss = r_q.xyz[95:64];
              r_d.meas.apply_measurement = r_q.ctl[`AFSP_CTL_USE];
              r_d.meas.x_axis_valid = r_q.ctl[`AFSP_CTL_XV] & r_q.ctl[`AFSP_CTL_USE];
              r_d.meas.y_axis_valid = r_q.ctl[`AFSP_CTL_YV] & r_q.ctl[`AFSP_CTL_USE];
              r_d.meas.z_axis_valid = r_q.ctl[`AFSP_CTL_ZV] & r_q.ctl[`AFSP_CTL_USE];
              r_d.strobe = 1'b1;
              if (r_q.id == `AFSP_ID_EXTENDED) begin
                r_d.ext_seen = 1'b1;
              end
            end
          end
        end
        default: begin
          r_d.st = AFSP_HUNT;
        end
      endcase
    end
    // register writes
    if (REG_WR) begin
      unique case (REG_ADDR)
        `AFSP_REG_CTRL: r_d.enable = REG_WDATA[0];
        `AFSP_REG_MODE: r_d.mode = afsp_mode_t'({6'h00, REG_WDATA[1:0]});
        `AFSP_REG_DROPS: r_d.drops = 16'h0000;
        default: ;
      endcase
      if (REG_ADDR == `AFSP_REG_CTRL && !REG_WDATA[0]) begin
        r_d.st = AFSP_HUNT;
      end
    end
    // register reads, data in the next cycle
    r_d.rdata = `AFSP_RST_WORD;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `AFSP_REG_CTRL:    r_d.rdata = {31'h0000_0000, r_q.enable};
        `AFSP_REG_MODE:    r_d.rdata = {24'h00_0000, r_q.mode};
        `AFSP_REG_STAT_LO: r_d.rdata = r_q.stat[31:0];
        `AFSP_REG_STAT_HI: r_d.rdata = r_q.stat[63:32];
        `AFSP_REG_FIELD_X_GAUSS:    r_d.rdata = r_q.meas.field_x_gauss;
        `AFSP_REG_FIELD_Y_GAUSS:    r_d.rdata = r_q.meas.field_y_gauss;
        `AFSP_REG_FIELD_Z_GAUSS:    r_d.rdata = r_q.meas.field_z_gauss;
        `AFSP_REG_RXINFO:  r_d.rdata = {21'h00_0000, r_q.st, r_q.ext_seen, r_q.meas.apply_measurement,
                                        r_q.meas.z_axis_valid, r_q.meas.y_axis_valid,
                                        r_q.meas.x_axis_valid, 1'b0, 1'b0, 1'b0};
        `AFSP_REG_DROPS:   r_d.rdata = {16'h0000, r_q.drops};
        default:           r_d.rdata = `AFSP_RST_WORD;
      endcase
    end
  end

  // state register
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      r_q <= '0;
      r_q.enable <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flops
  assign REG_RDATA = r_q.rdata;
  assign MEAS = r_q.meas;
  assign MEAS_STROBE = r_q.strobe;
  assign EXT_SEEN = r_q.ext_seen;
  assign STATUS_WORD = r_q.stat;
  assign MODE_WORD = {24'h00_0000, r_q.mode};

  status_rsv_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    STATUS_WORD.rsv == 8'h00 && STATUS_WORD.imu.rsv == 1'b0
      && STATUS_WORD.imu.spare == 7'h00)
    else $error("status reserved bits not zero");
  imu_flags_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ##1 STATUS_WORD[13:8] == $past(IMU_STATUS[5:0]))
    else $error("inertial flags misplaced");
  crc_count_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ##1 STATUS_WORD[22:14] == $past(IMU_STATUS.crc_fail_count))
    else $error("checksum count misplaced");
  mag_byte_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ##1 STATUS_WORD[47:40] == {6'h00, $past(MAG_STATUS.valid_read), $past(MAG_STATUS.ready)})
    else $error("magnetometer byte wrong");
  mode_word_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    MODE_WORD[31:8] == 24'h00_0000 && MODE_WORD[7:2] == 6'h00)
    else $error("mode word reserved bytes set");
  // frame accepted only after checksum state
  frame_end_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    MEAS_STROBE |-> $past(r_q.st) == AFSP_CRC && $past(frame_known(r_q.id, r_q.len)))
    else $error("strobe without good frame");
  crc_drop_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    good_end && r_q.enable && !CRC_OK |=> !MEAS_STROBE && r_q.st == AFSP_HUNT)
    else $error("bad checksum frame forwarded");
  use_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !MEAS.apply_measurement |-> !(MEAS.x_axis_valid | MEAS.y_axis_valid | MEAS.z_axis_valid))
    else $error("axis valid without use bit");
  sync_count_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ##1 STATUS_WORD[31:23] == $past(IMU_STATUS.sync_count))
    else $error("sync count misplaced");
  baro_byte_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ##1 STATUS_WORD[55:48] == {6'h00, $past(BARO_STATUS.valid_read), $past(BARO_STATUS.ready)})
    else $error("barometer byte wrong");
  sat_byte_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ##1 STATUS_WORD[63:56] == {6'h00, $past(SAT_STATUS.second_ready), $past(SAT_STATUS.first_ready)})
    else $error("receiver byte wrong");
  strobe_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    MEAS_STROBE |=> !MEAS_STROBE)
    else $error("strobe longer than one cycle");
  len_drop_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    r_q.st == AFSP_LEN && r_q.cnt == 2'h1 && RX_VALID && r_q.enable
      && !frame_known(r_q.id, {RX_DATA, r_q.len[15:8]}) |=> r_q.st == AFSP_HUNT)
    else $error("bad length frame kept");
  // only the preamble leaves the hunt
  preamble_hunt_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    r_q.st == AFSP_HUNT && RX_VALID && RX_DATA != `AFSP_PREAMBLE
      |=> r_q.st == AFSP_HUNT)
    else $error("hunt left without preamble");
  ext_sticky_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    EXT_SEEN |=> EXT_SEEN)
    else $error("extended flag dropped");
  // measurement changes only with a strobe
  meas_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !MEAS_STROBE |-> $stable(MEAS))
    else $error("measurement changed without strobe");
endmodule

/* File: afsp_aider.sv */
`timescale 1ns/1ps
module afsp_aider (
  // clock
  input  wire logic       sys_clk,
  // byte stream toward the unit
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            crc_ok
);
  // idle line at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    crc_ok   = 1'b0;
  end
  task automatic send(input logic [23:0] id, input logic [15:0] len, input logic [7:0] ctl,
                      input logic [31:0] x, y, z, input logic good, input int gap);
    logic [7:0]  fb[$];
    logic [95:0] f;
    f  = {z, y, x};
    fb = {8'h3D, id[7:0], id[15:8], id[23:16], len[7:0], len[15:8], ctl};
    // floats at offsets 1, 5 and 9
    for (int i = 0; i < 12; i++) begin
      fb.push_back(f[8*i +: 8]);
    end
    while (fb.size() < 6 + len) begin
      fb.push_back(8'h00);
    end
    fb.push_back(8'h94);
    fb.push_back(8'h81);
    // one byte per edge; idle data is the inverse of the last byte
    foreach (fb[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= fb[i];
      crc_ok   <= good && (i == fb.size() - 1);
      @(posedge sys_clk);
      if (gap > 0 || i == fb.size() - 1) begin
        rx_valid <= 1'b0;
        rx_data  <= ~fb[i];
        crc_ok   <= 1'b0;
        // no gap after the last byte, so the caller sees the strobe
        if (i < fb.size() - 1) begin
          repeat (gap) @(posedge sys_clk);
        end
      end
    end
  endtask
endmodule

/* File: afsp_packer_test.sv */
`timescale 1ns/1ps
`include "afsp_map.svh"
module afsp_packer_test;
  import afsp_pkg::*;
  localparam logic [31:0] FX = 32'h3EFD_8A2F;
  localparam logic [31:0] FY = 32'h3E4E_EEA5;
  localparam logic [31:0] FZ = 32'hBF1B_81B6;
  logic         clk, rstn, rx_valid, crc_ok, wr, rd, strobe, ext_seen;
  logic [7:0]   rx_data;
  logic [3:0]   addr;
  logic [31:0]  wdata, rdata, mode_word;
  afsp_imu_t    imu;
  afsp_sensor_t mag, baro;
  afsp_sat_t    sat;
  afsp_meas_t   meas;
  afsp_status_t status;
  int           failures, checks, n;

  afsp_aider aider_u (.sys_clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .crc_ok(crc_ok));
  afsp_packer dut_u (.SYS_CLK(clk), .RESETN(rstn), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .CRC_OK(crc_ok), .IMU_STATUS(imu), .MAG_STATUS(mag), .BARO_STATUS(baro),
    .SAT_STATUS(sat), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .MEAS(meas), .MEAS_STROBE(strobe), .EXT_SEEN(ext_seen),
    .STATUS_WORD(status), .MODE_WORD(mode_word));

  // clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // compare and count
  task automatic check(input string what, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
    @(posedge clk);
  endtask
  task automatic stat(input logic [31:0] i, input logic [7:0] m, b, s, input logic [63:0] e);
    imu  <= i;
    mag  <= m;
    baro <= b;
    sat  <= s;
    repeat (2) @(posedge clk);
    check("status lo", status[31:0], e[31:0]);
    check("status hi", status[63:32], e[63:32]);
    rd_chk(`AFSP_REG_STAT_LO, e[31:0], "status lo reg");
    rd_chk(`AFSP_REG_STAT_HI, e[63:32], "status hi reg");
  endtask
  // send a frame and count strobes just after it
  task automatic frame(input logic [23:0] id, input logic [15:0] len, input logic [7:0] ctl,
                       input logic good, input int gap, input int exp);
    aider_u.send(id, len, ctl, FX, FY, FZ, good, gap);
    n = 0;
    repeat (4) begin
      #1;
      if (strobe === 1'b1) n++;
      @(posedge clk);
    end
    check("strobe count", n, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (6000) @(posedge clk);
    failures++;
    $display("Error watchdog expected end seen hang");
    give_verdict;
  end
  // main sequence
  initial begin
    rstn  = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 4'h0;
    wdata = 32'h0000_0000;
    imu   = 32'h0000_0000;
    mag   = 8'h00;
    baro  = 8'h00;
    sat   = 8'h00;
    repeat (20) @(posedge clk);
    check("reset words", status[31:0] | status[63:32] | mode_word, 32'h0000_0000);
    rstn <= 1'b1;
    rd_chk(`AFSP_REG_CTRL, 32'h0000_0001, "ctrl reset");
    stat(32'hA5A5_5A5A, 8'hFF, 8'hFE, 8'hFD, 64'h0102_0300_A55A_5A00);
    stat(32'h0000_0001, 8'h01, 8'h02, 8'h02, 64'h0202_0100_0000_0100);
    stat(32'h0000_8040, 8'h02, 8'h01, 8'h01, 64'h0101_0200_0080_4000);
    $display("test status done");
    for (int m = 0; m < 4; m++) begin
      reg_wr(`AFSP_REG_MODE, m);
      rd_chk(`AFSP_REG_MODE, m, "mode reg");
      check("mode word", mode_word, m);
    end
    reg_wr(`AFSP_REG_MODE, 32'hFFFF_FFFC);
    rd_chk(`AFSP_REG_MODE, 32'h0000_0000, "mode masked");
    $display("test mode done");
    frame(`AFSP_ID_BASIC, `AFSP_LEN_BASIC, 8'h0F, 1'b1, 0, 1);
    check("x", meas.field_x_gauss, FX);
    check("y", meas.field_y_gauss, FY);
    check("z", meas.field_z_gauss, FZ);
    check("ctl", {meas.x_axis_valid, meas.y_axis_valid, meas.z_axis_valid,
                  meas.apply_measurement}, 32'h0000_000F);
    rd_chk(`AFSP_REG_FIELD_Y_GAUSS, FY, "mag y reg");
    $display("test good frame done");
    frame(`AFSP_ID_BASIC, `AFSP_LEN_BASIC, 8'h0F, 1'b0, 1, 0);
    frame(`AFSP_ID_BASIC, `AFSP_LEN_BASIC, 8'h1F, 1'b1, 0, 0);
    frame(`AFSP_ID_BASIC, 16'h000C, 8'h0F, 1'b1, 2, 0);
    rd_chk(`AFSP_REG_DROPS, 32'h0000_0003, "drop count");
    frame(`AFSP_ID_BASIC, `AFSP_LEN_BASIC, 8'h07, 1'b1, 0, 1);
    check("use clear", {meas.x_axis_valid, meas.y_axis_valid, meas.z_axis_valid,
                        meas.apply_measurement}, 32'h0000_0000);
    $display("test bad frames done");
    check("ext before", ext_seen, 32'h0000_0000);
    frame(`AFSP_ID_EXTENDED, 16'h005E, 8'h0F, 1'b1, 0, 1);
    check("ext after", ext_seen, 32'h0000_0001);
    rd_chk(`AFSP_REG_RXINFO, 32'h0000_00F8, "rx info");
    reg_wr(`AFSP_REG_CTRL, 32'h0000_0000);
    frame(`AFSP_ID_BASIC, `AFSP_LEN_BASIC, 8'h0F, 1'b1, 0, 0);
    reg_wr(`AFSP_REG_CTRL, 32'h0000_0001);
    rd_chk(`AFSP_REG_CTRL, 32'h0000_0001, "ctrl enable");
    frame(`AFSP_ID_BASIC, `AFSP_LEN_BASIC, 8'h0F, 1'b1, 1, 1);
    reg_wr(`AFSP_REG_DROPS, 32'h0000_0000);
    rd_chk(`AFSP_REG_DROPS, 32'h0000_0000, "drops cleared");
    rd_chk(4'hF, 32'h0000_0000, "unmapped");
    $display("test extended done");
    give_verdict;
  end
endmodule
